// File: common/pdm_regs.vh
// register map, field positions, reset values and timing counts of the power-down controller
`ifndef PDM_REGS_VH
`define PDM_REGS_VH
`define PDM_ADDR_W          16
`define PDM_OFS_MSTBY       16'hff5e
`define PDM_OFS_SYSCTL      16'hfff2
`define PDM_OFS_STATUS      16'hfff4
`define PDM_RST_MSTBY       8'h40
`define PDM_RST_SYSCTL      8'h0b
`define PDM_BIT_SOFT_HW_STANDBY_PIN_SEL 7
`define PDM_BIT_STS_HI      6
`define PDM_BIT_STS_LO      4
`define PDM_BIT_RAM_EN      0
`define PDM_BIT_CKSTOP      7
`define PDM_BIT_FIXED1      6
`define PDM_BIT_TMR         5
`define PDM_BIT_SER0        4
`define PDM_BIT_SER1        3
`define PDM_BIT_ADC         0
`define PDM_MSTBY_WMASK     8'hb9
`define PDM_WAIT_0          32'd8192
`define PDM_WAIT_1          32'd16384
`define PDM_WAIT_2          32'd32768
`define PDM_WAIT_3          32'd65536
`define PDM_WAIT_4          32'd131072
`define PDM_WAIT_5          32'd1024
`define PDM_MODE_RUN        2'h0
`define PDM_MODE_SLEEP      2'h1
`define PDM_MODE_SSTBY      2'h2
`define PDM_MODE_SETTLE     2'h3
`endif

// File: design/pdm_settle_timer.v
// clock-settling wait counter for software standby exit
`include "pdm_regs.vh"

module pdm_settle_timer #(
  parameter CNT_W = 18
) (
  input  wire             ref_clk,
  input  wire             nrst,
  input  wire             start,
  input  wire [2:0]       sel,
  input  wire [31:0]      scale_div,
  output reg              busy,
  output wire             done
);

  reg  [CNT_W-1:0] cnt_reg;
  wire [CNT_W-1:0] len_w;
  wire [31:0]      len_full;

  // code to state count; illegal codes fall back to the shortest wait
  function [31:0] wait_len;
    input [2:0] code;
    begin
      case (code)
        3'h0:    wait_len = `PDM_WAIT_0;
        3'h1:    wait_len = `PDM_WAIT_1;
        3'h2:    wait_len = `PDM_WAIT_2;
        3'h3:    wait_len = `PDM_WAIT_3;
        3'h4:    wait_len = `PDM_WAIT_4;
        3'h5:    wait_len = `PDM_WAIT_5;
        default: wait_len = `PDM_WAIT_5;
      endcase
    end
  endfunction

  // scale_div lets a simulation shorten the wait; 1 gives the true count
  assign len_full = wait_len(sel) / scale_div;
  assign len_w    = len_full[CNT_W-1:0];
  assign done  = busy && (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1});

  // load on start, count down to one
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy    <= 1'b0;
      cnt_reg <= {CNT_W{1'b0}};
    end else if (start) begin
      busy    <= 1'b1;
      cnt_reg <= len_w;
    end else if (busy) begin
      if (done) begin
        busy <= 1'b0;
      end
      cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// File: design/pdm_power_ctrl.v
// power-down controller: system and module standby registers, sleep and standby sequencing
`include "pdm_regs.vh"

// register map, one byte each on lane 0 of the bus
//   system control: standby select, settle code, ram enable
//   module standby control: clock-out stop and four peripheral holds
//   status, read only: settle counter busy and the current mode
// unmapped addresses are answered so a stray access cannot hang the bus
//
// bus timing
//   a request is taken on the edge where cyc and stb are high and ack low
//   a write takes effect on the edge that takes the request
//   ack follows one cycle later and lasts one cycle
//   the ack is registered, so the answer never depends on input paths
//   read data is registered and holds until the next read
//   cyc and stb are ignored in the ack cycle, so requests lie at least two cycles apart
//
// operating modes
//   run: cpu and clock active, peripherals follow their own standby bits
//   sleep: cpu halted, clock and peripherals keep running
//   software standby: clock halted, every peripheral held in reset
//   settling: oscillator restarting, wait counted before release
//   hardware standby: pin low, both registers reloaded, all halts high
//
// mode changes
//   run to sleep: sleep pulse with the standby select bit clear
//   run to software standby: sleep pulse with the select bit set
//   sleep to run: any interrupt, ordinary or external
//   wakeup from sleep does not pass through the settle wait
//   software standby to settling: external interrupt only
//   settling to run: selected wait has elapsed
//   any mode to run: hardware standby pin, held there while low
//
// why only an external interrupt leaves software standby: an ordinary
// source needs the clock to raise its request, and the clock is stopped
//
// settle wait
//   the three-bit code picks the count of states before clocks return
//   the wait counts down from the loaded length to one
//   codes six and seven are stored as written; the counter then uses
//   the shortest wait, which software must not rely on
//   a divider parameter shortens every wait for simulation only
//
// reset and reload
//   chip reset loads system control with 0b hex and module standby with 40 hex
//   hardware standby reloads both and forces run mode while the pin is low
//   software standby changes neither register
//
// outputs
//   cpu halt: high in sleep, software standby, settling and hardware standby
//   clock halt: high in software standby, settling and hardware standby
//   clock-out enable: low when the stop bit is set or the clock is halted
//   peripheral holds: own bit, or high whenever the clock is halted
//   ram enable: bit 0 of system control, passed straight out
//   power mode: run, sleep, software standby, settling, as two bits
//
// hazards
//   a sleep pulse and an external interrupt in one cycle: the pulse wins,
//   the interrupt is seen on the next cycle in the new mode
//   a settle code rewritten during the wait takes effect at the next exit,
//   the count in progress was loaded at the start
//   the pin input is filtered by agreement of two stages, so a one-cycle
//   glitch on the pin does not enter hardware standby
//   a bus write in the same cycle as the pin reload loses to the reload
//
// limitations
//   the standby select bit is never cleared by hardware on wakeup;
//   software clears it by writing zero
//   the module standby register keeps its value through software
//   standby, so peripherals return to their held state after wakeup
//   the pin path adds three to four cycles before hardware standby acts
//   writes with lane 0 disabled are ignored; upper lanes are not used
//   the status register is a convenience for test software and has no
//   effect on any mode change
//   peripheral holds are levels; each peripheral decides how to reset

module pdm_power_ctrl #(
  parameter WAIT_DIV = 32'd1
) (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        sleep_exec,
  input  wire        ext_irq,
  input  wire        wake_irq,
  input  wire        hw_standby_pin_n,
  output wire        cpu_halt,
  output wire        clock_halt,
  output wire        clock_out_en,
  output wire        timer_unit_standby,
  output wire        serial0_standby,
  output wire        serial1_standby,
  output wire        adc_standby,
  output wire        onchip_ram_enable,
  output wire [1:0]  power_mode
);

  // software-visible registers
  reg  [7:0]  system_control_reg;
  reg  [7:0]  module_standby_control_reg;
  // power mode state and its next value
  reg  [1:0]  mode_reg;
  reg  [1:0]  mode_next;
  // standby pin synchroniser and its filtered level
  reg  [2:0]  pin_sync_reg;
  reg         hw_standby_reg;
  // settle counter handshake
  reg         settle_start;
  wire        settle_busy;
  wire        settle_done;
  // bus decode
  wire        wb_req;
  wire        wb_wr;
  wire        hit_sys;
  wire        hit_mst;
  wire        hit_stat;
  // read mux output
  reg  [7:0]  rd_byte;

  // mode codes, also reported in the status register
  localparam MODE_RUN    = `PDM_MODE_RUN;
  localparam MODE_SLEEP  = `PDM_MODE_SLEEP;
  localparam MODE_SSTBY  = `PDM_MODE_SSTBY;
  localparam MODE_SETTLE = `PDM_MODE_SETTLE;
  localparam N_PERIPH    = 4;

  // one hold per peripheral: timer unit, serial 0, serial 1, converter
  wire [N_PERIPH-1:0] periph_hold;

  // address compare shared by the write decode and the read mux
  function addr_is;
    input [15:0] adr;
    input [15:0] ofs;
    begin
      addr_is = (adr == ofs);
    end
  endfunction

  // modes in which the clock tree is stopped
  function mode_clock_off;
    input [1:0] mode;
    begin
      mode_clock_off = (mode == MODE_SSTBY) || (mode == MODE_SETTLE);
    end
  endfunction

  // modes in which the cpu does not fetch
  function mode_cpu_off;
    input [1:0] mode;
    begin
      mode_cpu_off = (mode != MODE_RUN);
    end
  endfunction

  // own standby bit of peripheral idx, in hold-vector order
  function periph_sel;
    input [7:0]   mreg;
    input integer idx;
    begin
      case (idx)
        0:       periph_sel = mreg[`PDM_BIT_TMR];
        1:       periph_sel = mreg[`PDM_BIT_SER0];
        2:       periph_sel = mreg[`PDM_BIT_SER1];
        default: periph_sel = mreg[`PDM_BIT_ADC];
      endcase
    end
  endfunction

  // value stored on a write: fixed bit forced, reserved bits dropped
  function [7:0] mstby_store;
    input [7:0] wdat;
    begin
      mstby_store = (wdat & `PDM_MSTBY_WMASK) | 8'h40;
    end
  endfunction

  // status byte: settle counter busy and current mode
  function [7:0] status_byte;
    input       busy;
    input [1:0] mode;
    begin
      status_byte = {5'h00, busy, mode};
    end
  endfunction

  // standby pin crosses in through three stages; level changes when stages two and three agree
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_reg   <= 3'h7;
      hw_standby_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], hw_standby_pin_n};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        hw_standby_reg <= ~pin_sync_reg[2];
      end
    end
  end

  // wishbone classic slave, ack one cycle after request, dropped next cycle
  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
  assign hit_sys  = addr_is(wb_adr_i, `PDM_OFS_SYSCTL);
  assign hit_mst  = addr_is(wb_adr_i, `PDM_OFS_MSTBY);
  assign hit_stat = addr_is(wb_adr_i, `PDM_OFS_STATUS);

  // read mux; unmapped addresses read zero and still ack
  always @* begin
    rd_byte = 8'h00;
    if (hit_sys) begin
      rd_byte = system_control_reg;
    end else if (hit_mst) begin
      rd_byte = module_standby_control_reg | 8'h40;
    end else if (hit_stat) begin
      rd_byte = status_byte(settle_busy, mode_reg);
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // system control register: only software writes, reset and hw standby change it, so the standby bit survives wakeup
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      system_control_reg <= `PDM_RST_SYSCTL;
    end else if (hw_standby_reg) begin
      system_control_reg <= `PDM_RST_SYSCTL;
    end else if (wb_wr && hit_sys) begin
      system_control_reg <= wb_dat_i[7:0];
    end
  end

  // module standby register: reset and hw standby load 40h, software standby leaves it alone
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      module_standby_control_reg <= `PDM_RST_MSTBY;
    end else if (hw_standby_reg) begin
      module_standby_control_reg <= `PDM_RST_MSTBY;
    end else if (wb_wr && hit_mst) begin
      // bit 6 fixed, bits 2:1 reserved and kept zero
      module_standby_control_reg <= mstby_store(wb_dat_i[7:0]);
    end
  end

  // power mode sequencing
  always @* begin
    mode_next    = mode_reg;
    settle_start = 1'b0;
    case (mode_reg)
      // a sleep pulse outside run mode is ignored
      MODE_RUN: begin
        if (sleep_exec) begin
          if (system_control_reg[`PDM_BIT_SOFT_HW_STANDBY_PIN_SEL]) begin
            mode_next = MODE_SSTBY;
          end else begin
            mode_next = MODE_SLEEP;
          end
        end
      end
      // clock still runs, so any interrupt can wake the cpu
      MODE_SLEEP: begin
        if (wake_irq || ext_irq) begin
          mode_next = MODE_RUN;
        end
      end
      // clock stopped: only an external interrupt restarts it
      MODE_SSTBY: begin
        if (ext_irq) begin
          mode_next    = MODE_SETTLE;
          settle_start = 1'b1;
        end
      end
      // cpu and peripherals stay held until the count ends
      MODE_SETTLE: begin
        if (settle_done) begin
          mode_next = MODE_RUN;
        end
      end
      // unused code cannot occur; recover to run
      default: begin
        mode_next = MODE_RUN;
      end
    endcase
  end

  // hardware standby pin overrides every mode
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_RUN;
    end else if (hw_standby_reg) begin
      mode_reg <= MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  pdm_settle_timer #(
    .CNT_W (18)
  ) u_settle (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .start     (settle_start),
    .sel       (system_control_reg[`PDM_BIT_STS_HI:`PDM_BIT_STS_LO]),
    .scale_div (WAIT_DIV),
    .busy      (settle_busy),
    .done      (settle_done)
  );

  // cpu halts in every low-power mode; clock stops in software standby and its settling wait
  assign cpu_halt   = mode_cpu_off(mode_reg) || hw_standby_reg;
  assign clock_halt = mode_clock_off(mode_reg) || hw_standby_reg;
  assign clock_out_en = !module_standby_control_reg[`PDM_BIT_CKSTOP] && !clock_halt;
  assign power_mode = mode_reg;
  assign onchip_ram_enable = system_control_reg[`PDM_BIT_RAM_EN];

  // peripheral hold-in-reset: own bit, or whole chip in software standby, its settling wait or hardware standby
  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi = gi + 1) begin : g_hold
      assign periph_hold[gi] = periph_sel(module_standby_control_reg, gi) || clock_halt;
    end
  endgenerate

  // the holds reach the peripherals as separate lines
  assign timer_unit_standby = periph_hold[0];
  assign serial0_standby    = periph_hold[1];
  assign serial1_standby    = periph_hold[2];
  assign adc_standby        = periph_hold[3];

endmodule

// File: verif/pdm_power_ctrl_properties.sv
// port checker for the power-down controller
module pdm_power_props #(
  parameter WAIT_DIV = 32'd1
) (
  input wire       ref_clk,
  input wire       nrst,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input logic      wb_ack_o,
  input wire       ext_irq,
  input wire       hw_standby_pin_n,
  input wire       cpu_halt,
  input wire       clock_halt,
  input wire       clock_out_en,
  input wire       timer_unit_standby,
  input wire       serial0_standby,
  input wire       serial1_standby,
  input wire       adc_standby,
  input wire [1:0] power_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // all four peripheral holds together
  wire sb = timer_unit_standby & serial0_standby & serial1_standby & adc_standby;

  AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  AST_ACK_ONE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_SLEEP_RUNS:
    assert property (power_mode == 2'h1 |-> cpu_halt && !clock_halt) else $error("sleep");
  AST_SSTBY_ALL:
    assert property (power_mode == 2'h2 |-> clock_halt && sb) else $error("standby");
  AST_CLKOUT:
    assert property (clock_halt |-> !clock_out_en) else $error("clock out");
  AST_SETTLE_FROM:
    assert property ($rose(power_mode == 2'h3) |-> $past(power_mode) == 2'h2)
      else $error("settle source");
  AST_SLEEP_NO_SETTLE:
    assert property (power_mode == 2'h1 |=> power_mode != 2'h3) else $error("sleep settle");
  AST_IRQ_SETTLE:
    assert property (power_mode == 2'h2 && ext_irq && hw_standby_pin_n |=> power_mode == 2'h3)
      else $error("irq exit");
  AST_SETTLE_MIN:
    assert property ($rose(power_mode == 2'h3) |-> (power_mode == 2'h3)[*8])
      else $error("settle short");
  // main modes reached
  cover property (power_mode == 2'h1);
  cover property (power_mode == 2'h2);
  cover property (power_mode == 2'h3);
endmodule

bind pdm_power_ctrl pdm_power_props #(.WAIT_DIV(WAIT_DIV)) pdm_power_props_inst (.*);

// File: verif/pdm_cpu_model.sv
// cpu core model: sleep instruction pulse and external interrupt
module pdm_cpu_model (
  input  wire  ref_clk,
  input  wire  do_sleep,
  input  wire  do_wake,
  output logic sleep_exec,
  output logic ext_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // one flop stage, like an instruction decode
  initial begin
    sleep_exec = 1'b0;
    ext_irq = 1'b0;
  end
  always @(posedge ref_clk) begin
    sleep_exec <= do_sleep;
    ext_irq <= do_wake;
  end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the power-down controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] a; logic [7:0] w, r; logic [4:0] o;} pdm_row_t;
  logic        ref_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wake_irq;
  logic        hw_standby_pin_n, do_sleep, do_wake, sleep_exec, ext_irq, cpu_halt;
  logic        clock_halt, clock_out_en, timer_unit_standby, serial0_standby;
  logic        serial1_standby, adc_standby, onchip_ram_enable;
  logic [15:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0]  power_mode;
  logic [7:0]  rd;
  int          err_total, cmp_count, cyc_cnt, n;
  int          waits [7] = '{128, 256, 512, 1024, 2048, 16, 16};
  wire [7:0]   outs = {3'h0, clock_out_en, timer_unit_standby, serial0_standby,
                       serial1_standby, adc_standby};
  pdm_row_t    rows [7] = '{'{16'hff5e, 8'h00, 8'h40, 5'h10}, '{16'hff5e, 8'hff, 8'hf9, 5'h0f},
    '{16'hff5e, 8'h20, 8'h60, 5'h18}, '{16'hff5e, 8'h18, 8'h58, 5'h16},
    '{16'hff5e, 8'h01, 8'h41, 5'h11}, '{16'hfff2, 8'heb, 8'heb, 5'h11},
    '{16'h1000, 8'hff, 8'h00, 5'h11}};

  pdm_power_ctrl #(.WAIT_DIV(64)) pdm_power_ctrl_inst (.*);
  pdm_cpu_model pdm_cpu_model_inst (.*);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard, well above the summed settle waits
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 12000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  // classic cycle: hold until ack, data taken at the ack edge
  task automatic bus(logic [15:0] a, logic [7:0] d, logic w);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // model adds one flop, the controller takes it at the next edge
  task automatic sleep_op();
    @(posedge ref_clk);
    do_sleep <= 1'b1;
    @(posedge ref_clk);
    do_sleep <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wake_irq, do_sleep, do_wake} = '0;
    hw_standby_pin_n = 1'b1;
    wb_sel_i = 4'h1;
    wb_adr_i = '0;
    wb_dat_i = '0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(16'hff5e, 8'h00, 1'b0);
    chk("mstby reset", rd, 8'h40);
    bus(16'hfff2, 8'h00, 1'b0);
    chk("sysctl reset", rd, 8'h0b);
    foreach (rows[i]) begin
      bus(rows[i].a, rows[i].w, 1'b1);
      bus(rows[i].a, 8'h00, 1'b0);
      chk("readback", rd, rows[i].r);
      chk("outputs", outs, {3'h0, rows[i].o});
    end
    // sleep halts the cpu and keeps the clock running
    bus(16'hfff2, 8'h0b, 1'b1);
    sleep_op();
    chk("sleep mode", {4'h0, power_mode, clock_halt, cpu_halt}, 8'h05);
    wake_irq <= 1'b1;
    while (power_mode !== 2'h0) @(posedge ref_clk);
    wake_irq <= 1'b0;
    // every legal settle code and illegal 110, exit by external interrupt
    bus(16'hff5e, 8'h08, 1'b1);
    for (int c = 0; c < 7; c++) begin
      bus(16'hfff2, {1'b1, 3'(c), 4'hb}, 1'b1);
      sleep_op();
      chk("standby", {power_mode, 1'b0, outs[4:0]}, 8'h8f);
      do_wake <= 1'b1;
      while (power_mode !== 2'h3) @(posedge ref_clk);
      for (n = 0; power_mode === 2'h3; n++) @(posedge ref_clk);
      do_wake <= 1'b0;
      chk("settle", 8'(n >= waits[c] - 1 && n <= waits[c] + 2), 8'h01);
    end
    bus(16'hfff2, 8'h00, 1'b0);
    chk("soft_standby_select kept", rd, 8'heb);
    bus(16'hff5e, 8'h00, 1'b0);
    chk("mstby kept", rd, 8'h48);
    // a write with lane 0 disabled changes nothing
    wb_sel_i <= 4'h0;
    bus(16'hff5e, 8'hff, 1'b1);
    wb_sel_i <= 4'h1;
    bus(16'hff5e, 8'h00, 1'b0);
    chk("lane off", rd, 8'h48);
    // ram enable cleared before the pin goes low
    bus(16'hfff2, 8'h0a, 1'b1);
    chk("ram enable", {7'h0, onchip_ram_enable}, 8'h00);
    hw_standby_pin_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    hw_standby_pin_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    bus(16'hff5e, 8'h00, 1'b0);
    chk("mstby hw", rd, 8'h40);
    bus(16'hfff2, 8'h00, 1'b0);
    chk("sysctl hw", rd, 8'h0b);
    chk("ram hw", {7'h0, onchip_ram_enable}, 8'h01);
    // reset in mid-run reloads the module standby register
    bus(16'hff5e, 8'hff, 1'b1);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("reset outs", outs, 8'h10);
    nrst <= 1'b1;
    bus(16'hff5e, 8'h00, 1'b0);
    chk("mstby rst", rd, 8'h40);
    end_of_test();
  end
endmodule
